// ===== core/thrint_pkg.sv
// Constants, register map and helper functions of the threshold interrupt block.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
package thrint_pkg;

    // Register indices; the byte address is four times the index.
    localparam logic [7:0] IDX_RESULT  = 8'h00;
    localparam logic [7:0] IDX_CONFIG  = 8'h01;
    localparam logic [7:0] IDX_LOW     = 8'h02;
    localparam logic [7:0] IDX_HIGH    = 8'h03;
    localparam logic [7:0] IDX_IRQ_STS = 8'h04;
    localparam logic [7:0] IDX_IRQ_MSK = 8'h05;

    // Configuration register field positions.
    localparam int CFG_RANGE_LSB = 12;
    localparam int CFG_FLAG_HIGH = 6;
    localparam int CFG_FLAG_LOW  = 5;
    localparam int CFG_LATCH     = 4;
    localparam int CFG_POLARITY  = 3;
    localparam int CFG_EXP_MASK  = 2;
    localparam int CFG_FAULT_LSB = 0;

    // Values after reset.
    localparam logic [3:0]  RANGE_RST    = 4'hc;
    localparam logic        LATCH_RST    = 1'b1;
    localparam logic        POLARITY_RST = 1'b0;
    localparam logic        EXP_MASK_RST = 1'b0;
    localparam logic [1:0]  FAULT_RST    = 2'h0;
    localparam logic [15:0] LOW_LIM_RST  = 16'h0000;
    localparam logic [15:0] HIGH_LIM_RST = 16'hbfff;
    localparam logic [15:0] RESULT_RST   = 16'h0000;

    // Range code that selects automatic full-scale ranging.
    localparam logic [3:0] RANGE_AUTO = 4'hc;

    // Interrupt status and mask bit positions.
    localparam int IRQ_LOW_TRIP  = 0;
    localparam int IRQ_HIGH_TRIP = 1;
    localparam int IRQ_NEW_RES   = 2;
    localparam int IRQ_BITS      = 3;

    localparam int FAULT_CNT_W = 4;

    // Scales a mantissa by its exponent so values of any exponent compare.
    function automatic logic [26:0] thrint_lux(input logic [15:0] value);
        thrint_lux = 27'(value[11:0]) << value[15:12];
    endfunction

    // Number of consecutive faults needed for each fault count code.
    function automatic logic [FAULT_CNT_W-1:0] thrint_need(input logic [1:0] code);
        thrint_need = 4'h1 << code;
    endfunction

endpackage

// ===== core/thrint_fault_run.sv
// Counts consecutive faulted measurements against one limit.
// Assumes one sample strobe per finished conversion.
module thrint_fault_run (
    input  wire logic                                i_clk,
    input  wire logic                                i_reset,
    input  wire logic                                i_sample,
    input  wire logic                                i_fault,
    input  wire logic [thrint_pkg::FAULT_CNT_W-1:0] i_need,
    output logic                                     o_trip
);

    typedef struct packed {
        logic [thrint_pkg::FAULT_CNT_W-1:0] cnt;
    } thrint_run_s;

    thrint_run_s st_r;
    thrint_run_s st_nxt;
    logic [thrint_pkg::FAULT_CNT_W-1:0] run;

    always_comb begin
        st_nxt = st_r;
        run    = st_r.cnt + 4'h1;
        o_trip = 1'b0;
        if (i_sample) begin
            if (!i_fault) begin
                st_nxt.cnt = '0;
            end else begin
                o_trip = (run >= i_need);
                if (st_r.cnt < i_need) begin
                    st_nxt.cnt = run;
                end
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

endmodule

// ===== core/thrint_top.sv
// Threshold interrupt reporting of a light sensor, with an APB register slave.
// Assumes a conversion engine that strobes each new result for one cycle
// and an open-drain interrupt pin with an external pull-up.
module thrint_top #(
    parameter int ADDR_W = 12
) (
    input  wire logic              i_clk,
    input  wire logic              i_reset,
    input  wire logic              i_psel,
    input  wire logic              i_penable,
    input  wire logic              i_pwrite,
    input  wire logic [ADDR_W-1:0] i_paddr,
    input  wire logic [31:0]       i_pwdata,
    output logic [31:0]            o_prdata,
    output logic                   o_pready,
    output logic                   o_pslverr,
    input  wire logic              i_result_valid,
    input  wire logic [15:0]       i_result,
    output logic                   o_int_pin_o,
    output logic                   o_int_pin_oe,
    output logic                   o_irq
);

    typedef struct packed {
        logic [3:0]                       range_select;
        logic                             latch;
        logic                             interrupt_polarity;
        logic                             exponent_mask_enable;
        logic [1:0]                       fault_count_select;
        logic                             high_threshold_flag;
        logic                             low_threshold_flag;
        logic                             int_active;
        logic [15:0]                      low_lim;
        logic [15:0]                      high_lim;
        logic [15:0]                      result;
        logic [thrint_pkg::IRQ_BITS-1:0]  irq_sts;
        logic [thrint_pkg::IRQ_BITS-1:0]  irq_msk;
        logic [thrint_pkg::IRQ_BITS-1:0]  irq_seen;
        logic [31:0]                      prdata;
        logic                             pready;
        logic                             pslverr;
        logic                             irq;
        logic                             int_oe;
    } thrint_state_s;

    thrint_state_s st_r;
    thrint_state_s st_nxt;

    logic [7:0]                          idx;
    logic                                setup;
    logic                                access;
    logic                                fault_high;
    logic                                fault_low;
    logic                                trip_high;
    logic                                trip_low;
    logic [thrint_pkg::FAULT_CNT_W-1:0] need;
    logic [15:0]                         cfg_view;
    logic [15:0]                         result_view;
    logic [31:0]                         rd_val;
    logic                                mapped;
    logic                                cfg_read_done;

    assign idx    = i_paddr[9:2];
    assign setup  = i_psel && !i_penable;
    assign access = i_psel && i_penable && st_r.pready;
    assign need   = thrint_pkg::thrint_need(st_r.fault_count_select);

    assign fault_high = thrint_pkg::thrint_lux(i_result)
                        > thrint_pkg::thrint_lux(st_r.high_lim);
    assign fault_low  = thrint_pkg::thrint_lux(i_result)
                        < thrint_pkg::thrint_lux(st_r.low_lim);

    thrint_fault_run u_run_high (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_sample (i_result_valid),
        .i_fault  (fault_high),
        .i_need   (need),
        .o_trip   (trip_high)
    );

    thrint_fault_run u_run_low (
        .i_clk    (i_clk),
        .i_reset  (i_reset),
        .i_sample (i_result_valid),
        .i_fault  (fault_low),
        .i_need   (need),
        .o_trip   (trip_low)
    );

    // Configuration register as software sees it; unused bits read zero.
    always_comb begin
        cfg_view = '0;
        cfg_view[thrint_pkg::CFG_RANGE_LSB +: 4] = st_r.range_select;
        cfg_view[thrint_pkg::CFG_FLAG_HIGH]      = st_r.high_threshold_flag;
        cfg_view[thrint_pkg::CFG_FLAG_LOW]       = st_r.low_threshold_flag;
        cfg_view[thrint_pkg::CFG_LATCH]          = st_r.latch;
        cfg_view[thrint_pkg::CFG_POLARITY]       = st_r.interrupt_polarity;
        cfg_view[thrint_pkg::CFG_EXP_MASK]       = st_r.exponent_mask_enable;
        cfg_view[thrint_pkg::CFG_FAULT_LSB +: 2] = st_r.fault_count_select;
    end

    // Result register as software sees it.
    always_comb begin
        result_view = st_r.result;
        if (st_r.exponent_mask_enable && (st_r.range_select < thrint_pkg::RANGE_AUTO)) begin
            result_view[15:12] = 4'h0;
        end
    end

    // Read mux, evaluated in the setup phase.
    always_comb begin
        rd_val = '0;
        mapped = 1'b1;
        unique case (idx)
            thrint_pkg::IDX_RESULT:  rd_val[15:0] = result_view;
            thrint_pkg::IDX_CONFIG:  rd_val[15:0] = cfg_view;
            thrint_pkg::IDX_LOW:     rd_val[15:0] = st_r.low_lim;
            thrint_pkg::IDX_HIGH:    rd_val[15:0] = st_r.high_lim;
            thrint_pkg::IDX_IRQ_STS: rd_val[thrint_pkg::IRQ_BITS-1:0] = st_r.irq_sts;
            thrint_pkg::IDX_IRQ_MSK: rd_val[thrint_pkg::IRQ_BITS-1:0] = st_r.irq_msk;
            default:                 mapped = 1'b0;
        endcase
    end

    assign cfg_read_done = access && !i_pwrite && (idx == thrint_pkg::IDX_CONFIG);

    always_comb begin
        st_nxt = st_r;

        // Bus answer: one wait-free access phase after every setup.
        st_nxt.pready  = setup;
        st_nxt.pslverr = setup && !mapped;
        if (setup) begin
            st_nxt.prdata = i_pwrite ? 32'h0 : rd_val;
            st_nxt.irq_seen = '0;
            if (!i_pwrite && (idx == thrint_pkg::IDX_IRQ_STS)) begin
                st_nxt.irq_seen = st_r.irq_sts;
            end
        end else if (access) begin
            st_nxt.prdata   = '0;
            st_nxt.irq_seen = '0;
        end

        // Software writes; the flags have no write path.
        // flags read-only
        if (access && i_pwrite) begin
            unique case (idx)
                thrint_pkg::IDX_CONFIG: begin
                    st_nxt.range_select = i_pwdata[thrint_pkg::CFG_RANGE_LSB +: 4];
                    st_nxt.latch = i_pwdata[thrint_pkg::CFG_LATCH];
                    st_nxt.interrupt_polarity = i_pwdata[thrint_pkg::CFG_POLARITY];
                    st_nxt.exponent_mask_enable = i_pwdata[thrint_pkg::CFG_EXP_MASK];
                    st_nxt.fault_count_select = i_pwdata[thrint_pkg::CFG_FAULT_LSB +: 2];
                end
                thrint_pkg::IDX_LOW:     st_nxt.low_lim  = i_pwdata[15:0];
                thrint_pkg::IDX_HIGH:    st_nxt.high_lim = i_pwdata[15:0];
                thrint_pkg::IDX_IRQ_MSK: st_nxt.irq_msk  = i_pwdata[thrint_pkg::IRQ_BITS-1:0];
                default:                 st_nxt.low_lim  = st_r.low_lim;
            endcase
        end

        // in latched mode a config read is the clearing event
        if (st_r.latch && cfg_read_done) begin
            st_nxt.high_threshold_flag = 1'b0;
            st_nxt.low_threshold_flag  = 1'b0;
            st_nxt.int_active          = 1'b0;
        end

        // result and flags are set only on a new result
        if (i_result_valid) begin
            st_nxt.result = i_result;
            if (st_r.latch) begin
                if (trip_high) begin
                    st_nxt.high_threshold_flag = 1'b1;
                end
                if (trip_low) begin
                    st_nxt.low_threshold_flag = 1'b1;
                end
                if (trip_high || trip_low) begin
                    st_nxt.int_active = 1'b1;
                end
            end else begin
                st_nxt.high_threshold_flag = trip_high;
                st_nxt.low_threshold_flag = trip_low;
                if (trip_high) begin
                    st_nxt.int_active = 1'b1;
                end else if (trip_low) begin
                    st_nxt.int_active = 1'b0;
                end
            end
        end

        // Sticky status: a read clears what it returned, new events win.
        if (access && !i_pwrite && (idx == thrint_pkg::IDX_IRQ_STS)) begin
            st_nxt.irq_sts = st_r.irq_sts & ~st_r.irq_seen;
        end
        if (i_result_valid) begin
            st_nxt.irq_sts[thrint_pkg::IRQ_LOW_TRIP]  = st_nxt.irq_sts[thrint_pkg::IRQ_LOW_TRIP]
                                                        | trip_low;
            st_nxt.irq_sts[thrint_pkg::IRQ_HIGH_TRIP] = st_nxt.irq_sts[thrint_pkg::IRQ_HIGH_TRIP]
                                                        | trip_high;
            st_nxt.irq_sts[thrint_pkg::IRQ_NEW_RES]   = 1'b1;
        end
        st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_msk);

        // polarity 0 drives low when active
        st_nxt.int_oe = st_nxt.int_active ^ st_nxt.interrupt_polarity;
    end

    always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            st_r.range_select         <= thrint_pkg::RANGE_RST;
            st_r.latch                <= thrint_pkg::LATCH_RST;
            st_r.interrupt_polarity   <= thrint_pkg::POLARITY_RST;
            st_r.exponent_mask_enable <= thrint_pkg::EXP_MASK_RST;
            st_r.fault_count_select   <= thrint_pkg::FAULT_RST;
            st_r.high_threshold_flag  <= 1'b0;
            st_r.low_threshold_flag   <= 1'b0;
            st_r.int_active           <= 1'b0;
            st_r.low_lim              <= thrint_pkg::LOW_LIM_RST;
            st_r.high_lim             <= thrint_pkg::HIGH_LIM_RST;
            st_r.result               <= thrint_pkg::RESULT_RST;
            st_r.irq_sts              <= '0;
            st_r.irq_msk              <= '0;
            st_r.irq_seen             <= '0;
            st_r.prdata               <= '0;
            st_r.pready               <= 1'b0;
            st_r.pslverr              <= 1'b0;
            st_r.irq                  <= 1'b0;
            st_r.int_oe               <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // The pin is open drain: it only ever drives low.
    assign o_int_pin_o  = 1'b0;
    assign o_int_pin_oe = st_r.int_oe;
    assign o_prdata     = st_r.prdata;
    assign o_pready     = st_r.pready;
    assign o_pslverr    = st_r.pslverr;
    assign o_irq        = st_r.irq;

endmodule

// ===== verification/thrint_properties.sv
// Checker of the threshold interrupt block, watching only the top ports.
// Assumes the one-cycle APB answer and registered outputs of the design.
module thrint_properties #(
    parameter int ADDR_W = 12
) (
    input wire logic              i_clk,
    input wire logic              i_reset,
    input wire logic              i_psel,
    input wire logic              i_penable,
    input wire logic              i_pwrite,
    input wire logic [ADDR_W-1:0] i_paddr,
    input wire logic [31:0]       i_pwdata,
    input wire logic [31:0]       o_prdata,
    input wire logic              o_pready,
    input wire logic              o_pslverr,
    input wire logic              i_result_valid,
    input wire logic [15:0]       i_result,
    input wire logic              o_int_pin_o,
    input wire logic              o_int_pin_oe,
    input wire logic              o_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    ready_after_setup_a: assert property (i_psel && !i_penable |=> o_pready)
        else $error("pready missing after setup");
    ready_needs_setup_a: assert property (o_pready |-> $past(i_psel) && !$past(i_penable))
        else $error("pready without setup");
    unmapped_error_a: assert property (i_psel && !i_penable && i_paddr[9:2] > 8'h05 |=> o_pslverr)
        else $error("no error on unmapped index");
    mapped_no_error_a: assert property (i_psel && !i_penable && i_paddr[9:2] <= 8'h05 |=> !o_pslverr)
        else $error("error on mapped index");
    idle_data_zero_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access");
    pin_data_low_a: assert property (o_int_pin_o == 1'b0)
        else $error("pin data not low");
    pin_holds_idle_a: assert property ((!i_result_valid && !i_psel)[*3] |=> $stable(o_int_pin_oe))
        else $error("pin moved while idle");
    irq_rise_cause_a: assert property ($rose(o_irq) |->
        $past(i_result_valid) || $past(i_psel) || $past(i_result_valid, 2) || $past(i_psel, 2))
        else $error("irq rose without cause");
    irq_fall_cause_a: assert property ($fell(o_irq) |-> $past(i_psel) || $past(i_psel, 2))
        else $error("irq fell without access");
    ready_one_cycle_a: assert property (o_pready |=> !o_pready)
        else $error("pready held two cycles");
    error_with_ready_a: assert property (o_pslverr |-> o_pready)
        else $error("pslverr without pready");
    oe_change_cause_a: assert property ($changed(o_int_pin_oe) |->
        $past(i_result_valid) || $past(i_psel))
        else $error("pin enable moved without cause");
endmodule

bind thrint_top thrint_properties #(.ADDR_W(ADDR_W)) u_props (
    .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
    .o_pready(o_pready), .o_pslverr(o_pslverr), .i_result_valid(i_result_valid),
    .i_result(i_result), .o_int_pin_o(o_int_pin_o), .o_int_pin_oe(o_int_pin_oe),
    .o_irq(o_irq)
);

// ===== verification/thrint_host_pin.sv
// Host side of the interrupt line: an open-drain wire with a pull-up.
// Assumes the block only ever drives the pin low through its enable.
module thrint_host_pin (
    input  wire logic i_pin_o,
    input  wire logic i_pin_oe,
    output logic      o_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pull-up takes the line high whenever the block lets go of it.
    assign o_level = i_pin_oe ? i_pin_o : 1'b1;
endmodule

// ===== verification/threshold_interrupt_reporting_tb.sv
// Self-checking bench of the threshold interrupt block over APB.
// Assumes the register map and one-cycle APB answer of the block's design.
module threshold_interrupt_reporting_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk, i_reset, i_psel, i_penable, i_pwrite, i_result_valid;
    logic        o_pready, o_pslverr, o_int_pin_o, o_int_pin_oe, o_irq, pin, err;
    logic [11:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata, rd;
    logic [15:0] i_result;
    int          err_total, comparisons;

    thrint_top #(.ADDR_W(12)) uut (
        .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_result_valid(i_result_valid),
        .i_result(i_result), .o_int_pin_o(o_int_pin_o), .o_int_pin_oe(o_int_pin_oe),
        .o_irq(o_irq));
    thrint_host_pin u_host (.i_pin_o(o_int_pin_o), .i_pin_oe(o_int_pin_oe), .o_level(pin));

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Pready is taken at the rising edge, before that edge's own updates land.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel    <= 1'b1;
        i_penable <= 1'b0;
        i_pwrite  <= wr;
        i_paddr   <= a;
        i_pwdata  <= wd;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            err_total++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
        end
        rd        = o_prdata;
        err       = o_pslverr;
        i_psel    <= 1'b0;
        i_penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic meas(input logic [15:0] v, input int cnt);
        repeat (cnt) begin
            @(posedge i_clk);
            i_result_valid <= 1'b1;
            i_result <= v;
        end
        @(posedge i_clk);
        i_result_valid <= 1'b0;
    endtask

    task automatic pinchk(input logic exp);
        repeat (3) @(negedge i_clk);
        check({31'h0, pin}, {31'h0, exp});
    endtask

    initial begin
        #200000;
        err_total++;
        print_verdict();
    end

    initial begin
        i_reset = 1'b1;
        i_psel = 1'b0;
        i_penable = 1'b0;
        i_pwrite = 1'b0;
        i_paddr = 12'h000;
        i_pwdata = 32'h0;
        i_result_valid = 1'b0;
        i_result = 16'h0000;
        err_total = 0;
        comparisons = 0;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        rdchk(12'h004, 32'h0000c010);
        rdchk(12'h00c, 32'h0000bfff);
        pinchk(1'b1);
        apb(1'b0, 12'h040, 32'h0);
        check({rd[30:0], err}, 32'h1);
        apb(1'b1, 12'h004, 32'h0000c030);
        rdchk(12'h004, 32'h0000c010);
        apb(1'b1, 12'h014, 32'h2);
        rdchk(12'h014, 32'h00000002);
        $display("test reset_values done");
        for (int fc = 0; fc < 4; fc++) begin
            apb(1'b1, 12'h004, 32'h0000c010 | 32'(fc));
            apb(1'b0, 12'h010, 32'h0);
            meas(16'hc800, (1 << fc) - 1);
            meas(16'h0100, 1);
            meas(16'hc800, (1 << fc) - 1);
            pinchk(1'b1);
            check({31'h0, o_irq}, 32'h0);
            meas(16'hc800, 1);
            pinchk(1'b0);
            check({31'h0, o_irq}, 32'h1);
            meas(16'h0100, 1);
            pinchk(1'b0);
            rdchk(12'h004, 32'h0000c050 | 32'(fc));
            apb(1'b0, 12'h010, 32'h0);
            check(rd & 32'h2, 32'h2);
            pinchk(1'b1);
            check({31'h0, o_irq}, 32'h0);
        end
        $display("test fault_runs done");
        apb(1'b1, 12'h008, 32'h00000100);
        rdchk(12'h008, 32'h00000100);
        apb(1'b1, 12'h004, 32'h0000c008);
        pinchk(1'b0);
        meas(16'hc800, 1);
        pinchk(1'b1);
        rdchk(12'h004, 32'h0000c048);
        meas(16'h0200, 1);
        rdchk(12'h004, 32'h0000c008);
        pinchk(1'b1);
        meas(16'h0050, 1);
        pinchk(1'b0);
        rdchk(12'h004, 32'h0000c028);
        rdchk(12'h010, 32'h00000007);
        $display("test transparent done");
        apb(1'b1, 12'h004, 32'h00005014);
        rdchk(12'h004, 32'h00005034);
        meas(16'h3100, 1);
        rdchk(12'h000, 32'h00000100);
        meas(16'hc800, 1);
        rdchk(12'h000, 32'h00000800);
        rdchk(12'h004, 32'h00005054);
        apb(1'b1, 12'h004, 32'h0000c014);
        meas(16'h3100, 1);
        rdchk(12'h000, 32'h00003100);
        $display("test exponent_mask done");
        i_reset <= 1'b1;
        repeat (3) @(posedge i_clk);
        i_reset <= 1'b0;
        rdchk(12'h004, 32'h0000c010);
        rdchk(12'h014, 32'h00000000);
        pinchk(1'b1);
        $display("test mid_reset done");
        print_verdict();
    end
endmodule
